// File: uhif_top.sv
// usb hub interrupt flags: event status, acknowledge, enable, suspend/resume
// assumes ahb-lite master on i_core_clk; usb pins arrive asynchronous
// Behaviour
// - endpoint interrupt raised on its control/status triggers, by endpoint type
// - frame-start flag, bit 7, set on valid start-of-frame packet
// - frame-end warning flag, bit 6, set ten clocks before next frame
// - reserved bits of all these registers read as zero
// - bits 3..0 set on out received, setup received, transmit complete or stall sent
// - writing one to acknowledge bit clears that flag only
// - enable bit one lets the flag request interrupt, zero blocks it
// - wakeup flag, bit 2, set on external remote wakeup request
// - resume flag, bit 1, set on resume at ports other than one
// - global-suspend flag, bit 0, set on global suspend signalling
// - with bus-reset enable, bus reset resets engine only, sets bit 3
// - suspend/resume enables raise interrupt while matching status set
// - suspend/resume flags clear by writing zero to the bit
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module uhif_top
#(
    parameter int FRAME_CLKS     = uhif_pkg::FRAME_CLKS,
    parameter int BUS_RESET_CLKS = uhif_pkg::BUS_RESET_CLKS
)
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_hsel,
    input  wire logic [31:0]            i_haddr,
    input  wire logic [1:0]             i_htrans,
    input  wire logic                   i_hwrite,
    input  wire logic [2:0]             i_hsize,
    input  wire logic [31:0]            i_hwdata,
    input  wire logic                   i_hready,
    output logic [31:0]                 o_hrdata,
    output logic                        o_hreadyout,
    output logic                        o_hresp,
    input  wire logic                   i_sof_valid,
    input  wire uhif_pkg::uhif_ep_evt_t i_ep_evt,
    input  wire logic                   i_ext_wakeup,
    input  wire logic                   i_port_resume,
    input  wire logic                   i_glb_suspend,
    input  wire logic                   i_se0,
    output logic                        o_usb_engine_reset,
    output logic                        o_cpu_reset,
    output logic                        o_irq
);
    localparam logic [13:0] WARN_AT = 14'(uhif_pkg::FRAME_WARN_CLKS);

    // byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [15:0] idx);
        reg_addr = {14'h0000, idx, 2'h0};
    endfunction

    // pin synchronisers; first stage read only by the second
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    logic [3:0] pin_rise;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
        end
        else
        begin
            pin_meta_q <= {i_se0, i_glb_suspend, i_port_resume, i_ext_wakeup};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end
    assign pin_rise = pin_sync_q & ~pin_prev_q;

    // ahb address phase capture
    logic        ph_wr_q, ph_wr_d;
    logic        ph_rd_q, ph_rd_d;
    logic [31:0] ph_addr_q, ph_addr_d;
    always_comb
    begin
        ph_wr_d   = 1'b0;
        ph_rd_d   = 1'b0;
        ph_addr_d = ph_addr_q;
        if (i_hready && i_hsel && i_htrans == uhif_pkg::HTRANS_NONSEQ)
        begin
            ph_wr_d   = i_hwrite;
            ph_rd_d   = ~i_hwrite;
            ph_addr_d = i_haddr;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ph_wr_q   <= 1'b0;
            ph_rd_q   <= 1'b0;
            ph_addr_q <= 32'h0000_0000;
        end
        else
        begin
            ph_wr_q   <= ph_wr_d;
            ph_rd_q   <= ph_rd_d;
            ph_addr_q <= ph_addr_d;
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    logic wr_ack, wr_en, wr_sr_en, wr_sr_st, wr_ep_cfg;
    assign wr_ack    = ph_wr_q && ph_addr_q == reg_addr(uhif_pkg::IDX_EVENT_ACK);
    assign wr_en     = ph_wr_q && ph_addr_q == reg_addr(uhif_pkg::IDX_EVENT_ENABLE);
    assign wr_sr_en  = ph_wr_q && ph_addr_q == reg_addr(uhif_pkg::IDX_SR_ENABLE);
    assign wr_sr_st  = ph_wr_q && ph_addr_q == reg_addr(uhif_pkg::IDX_SR_STATUS);
    assign wr_ep_cfg = ph_wr_q && ph_addr_q == reg_addr(uhif_pkg::IDX_EP_CTRL);

    // endpoint trigger decode
    uhif_pkg::uhif_ep_cfg_t ep_cfg_q, ep_cfg_d;
    logic [uhif_pkg::NUM_EP-1:0] ep_trig;
    uhif_ep_detect u_ep_detect
    (
        .i_evt  (i_ep_evt),
        .i_cfg  (ep_cfg_q),
        .o_trig (ep_trig)
    );

    // frame timer: restarts on each sof, warns ahead of the next
    logic [31:0] frame_cnt_q, frame_cnt_d;
    logic        frame_warn;
    always_comb
    begin
        frame_cnt_d = frame_cnt_q + 32'h1;
        if (i_sof_valid)
            frame_cnt_d = 32'h0;
    end
    assign frame_warn = ~i_sof_valid
                      && frame_cnt_q == 32'(FRAME_CLKS) - 32'(WARN_AT) - 32'h1;

    // bus reset detection: se0 held longer than the limit
    logic [31:0] se0_cnt_q, se0_cnt_d;
    logic        bus_reset_hit;
    always_comb
    begin
        se0_cnt_d = 32'h0;
        if (pin_sync_q[3])
            se0_cnt_d = (se0_cnt_q == 32'(BUS_RESET_CLKS)) ? se0_cnt_q : se0_cnt_q + 32'h1;
    end
    assign bus_reset_hit = pin_sync_q[3] && se0_cnt_q == 32'(BUS_RESET_CLKS) - 32'h1;

    // flag registers
    logic [7:0] ev_stat_q, ev_stat_d;
    logic [7:0] ev_en_q, ev_en_d;
    logic [7:0] sr_stat_q, sr_stat_d;
    logic [7:0] sr_en_q, sr_en_d;
    logic [7:0] ev_set, sr_set;
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[uhif_pkg::BIT_FRAME_START] = i_sof_valid;
        ev_set[uhif_pkg::BIT_FRAME_END]   = frame_warn;
        ev_set[uhif_pkg::NUM_EP-1:0]      = ep_trig;
        sr_set = 8'h00;
        sr_set[uhif_pkg::BIT_FN_WAKEUP]   = pin_rise[0];
        sr_set[uhif_pkg::BIT_RESUME]      = pin_rise[1];
        sr_set[uhif_pkg::BIT_GLB_SUSPEND] = pin_rise[2];
        sr_set[uhif_pkg::BIT_BUS_RESET]   = bus_reset_hit
                                          & sr_en_q[uhif_pkg::BIT_BUS_RESET];
        ev_stat_d = ev_stat_q;
        if (wr_ack)
            ev_stat_d = ev_stat_q & ~i_hwdata[7:0];
        // set wins over a clear in the same cycle
        ev_stat_d = (ev_stat_d | ev_set) & uhif_pkg::EVENT_MASK;
        sr_stat_d = sr_stat_q;
        if (wr_sr_st)
            sr_stat_d = sr_stat_q & i_hwdata[7:0];
        sr_stat_d = (sr_stat_d | sr_set) & uhif_pkg::SR_MASK;
        ev_en_d = wr_en ? (i_hwdata[7:0] & uhif_pkg::EVENT_MASK) : ev_en_q;
        sr_en_d = wr_sr_en ? (i_hwdata[7:0] & uhif_pkg::SR_MASK) : sr_en_q;
        ep_cfg_d = wr_ep_cfg ? uhif_pkg::uhif_ep_cfg_t'(i_hwdata[7:0]) : ep_cfg_q;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ev_stat_q   <= uhif_pkg::RESET_VAL;
            ev_en_q     <= uhif_pkg::RESET_VAL;
            sr_stat_q   <= uhif_pkg::RESET_VAL;
            sr_en_q     <= uhif_pkg::RESET_VAL;
            ep_cfg_q    <= '0;
            frame_cnt_q <= 32'h0;
            se0_cnt_q   <= 32'h0;
        end
        else
        begin
            ev_stat_q   <= ev_stat_d;
            ev_en_q     <= ev_en_d;
            sr_stat_q   <= sr_stat_d;
            sr_en_q     <= sr_en_d;
            ep_cfg_q    <= ep_cfg_d;
            frame_cnt_q <= frame_cnt_d;
            se0_cnt_q   <= se0_cnt_d;
        end
    end

    // bus reset routing: engine always, cpu only when not separated
    logic eng_rst_q, eng_rst_d, cpu_rst_q, cpu_rst_d;
    always_comb
    begin
        eng_rst_d = bus_reset_hit;
        cpu_rst_d = bus_reset_hit & ~sr_en_q[uhif_pkg::BIT_BUS_RESET];
    end
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            eng_rst_q <= 1'b0;
            cpu_rst_q <= 1'b0;
        end
        else
        begin
            eng_rst_q <= eng_rst_d;
            cpu_rst_q <= cpu_rst_d;
        end
    end
    assign o_usb_engine_reset = eng_rst_q;
    assign o_cpu_reset        = cpu_rst_q;

    // interrupt: any enabled flag in either group
    assign o_irq = |(ev_stat_q & ev_en_q) | |(sr_stat_q & sr_en_q);

    // read data registered at the address-phase edge from next-state values,
    // so a write landing on that same edge is already seen; ack reads zero
    logic [7:0] rd_byte_q, rd_byte_d;
    always_comb
    begin
        rd_byte_d = 8'h00;
        if (ph_rd_d)
        begin
            if (ph_addr_d == reg_addr(uhif_pkg::IDX_EVENT_STATUS))
                rd_byte_d = ev_stat_d;
            else if (ph_addr_d == reg_addr(uhif_pkg::IDX_EVENT_ENABLE))
                rd_byte_d = ev_en_d;
            else if (ph_addr_d == reg_addr(uhif_pkg::IDX_SR_STATUS))
                rd_byte_d = sr_stat_d;
            else if (ph_addr_d == reg_addr(uhif_pkg::IDX_SR_ENABLE))
                rd_byte_d = sr_en_d;
            else if (ph_addr_d == reg_addr(uhif_pkg::IDX_EP_CTRL))
                rd_byte_d = ep_cfg_d;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rd_byte_q <= 8'h00;
        else
            rd_byte_q <= rd_byte_d;
    end
    assign o_hrdata = {24'h000000, rd_byte_q};

    chk_ack_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_ack && i_hwdata[7] && !i_sof_valid |=> !ev_stat_q[7])
        else $error("acknowledge did not clear frame-start flag");
    chk_ack_keeps: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_ack && !i_hwdata[0] && ev_stat_q[0] |=> ev_stat_q[0])
        else $error("acknowledge disturbed an unselected flag");
    chk_sof_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_sof_valid |=> ev_stat_q[7])
        else $error("frame-start flag not set");
    chk_warn_lead: assert property (@(posedge i_core_clk) disable iff (i_rst)
        frame_warn ##1 !i_sof_valid [*8] ##1 !i_sof_valid
        |=> frame_cnt_q == 32'(FRAME_CLKS) - 32'h1)
        else $error("frame-end warning not ten clocks ahead");
    chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ev_stat_q & ~uhif_pkg::EVENT_MASK) == 8'h00 && sr_stat_q[7:4] == 4'h0)
        else $error("reserved status bits set");
    chk_irq_masked: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ev_en_q == 8'h00 && sr_en_q == 8'h00) |-> !o_irq)
        else $error("interrupt with nothing enabled");
    chk_irq_raised: assert property (@(posedge i_core_clk) disable iff (i_rst)
        sr_stat_q[1] && sr_en_q[1] |-> o_irq)
        else $error("enabled resume did not interrupt");
    chk_wake_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(pin_sync_q[0]) |=> sr_stat_q[2])
        else $error("wakeup flag not set");
    chk_resume_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(pin_sync_q[1]) |=> sr_stat_q[1])
        else $error("resume flag not set");
    chk_susp_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(pin_sync_q[2]) |=> sr_stat_q[0])
        else $error("global suspend flag not set");
    chk_zero_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_sr_st && !i_hwdata[1] && !pin_rise[1] |=> !sr_stat_q[1])
        else $error("write zero did not clear resume flag");
    chk_bus_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
        bus_reset_hit && sr_en_q[3] |=> o_usb_engine_reset && !o_cpu_reset && sr_stat_q[3])
        else $error("separated bus reset misrouted");
    chk_ep_setup: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_ep_evt.rx_setup_set[0] && !ep_cfg_q.is_ctrl[0] && !i_ep_evt.rx_out_set[0]
        && !i_ep_evt.tx_complete_set[0] && !i_ep_evt.stall_sent_set[0]
        |=> ev_stat_q[0] == $past(ev_stat_q[0] && !(wr_ack && i_hwdata[0])))
        else $error("setup on non-control endpoint flagged");
endmodule // uhif_top
`default_nettype wire

// File: uhif_pkg.sv
// package for the usb hub interrupt flag block
// assumes an ahb-lite slave with 32-bit data, one register per aligned word
package uhif_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_EVENT_STATUS  = 16'h1ff7;
    localparam logic [15:0] IDX_SR_ENABLE     = 16'h1ff9;
    localparam logic [15:0] IDX_EVENT_ACK     = 16'h1ff8;
    localparam logic [15:0] IDX_EVENT_ENABLE  = 16'h1ffa;
    localparam logic [15:0] IDX_SR_STATUS     = 16'h1ffb;
    localparam logic [15:0] IDX_EP_CTRL       = 16'h1ffc;

    // event group bit positions
    localparam int BIT_FRAME_START   = 7;
    localparam int BIT_FRAME_END     = 6;
    localparam int BIT_HUB_EP0       = 3;
    localparam int BIT_FN_EP2        = 2;
    localparam int BIT_FN_EP1        = 1;
    localparam int BIT_FN_EP0        = 0;
    localparam int NUM_EP            = 4;
    localparam logic [7:0] EVENT_MASK = 8'hcf;

    // suspend/resume group bit positions
    localparam int BIT_BUS_RESET     = 3;
    localparam int BIT_FN_WAKEUP     = 2;
    localparam int BIT_RESUME        = 1;
    localparam int BIT_GLB_SUSPEND   = 0;
    localparam logic [7:0] SR_MASK   = 8'h0f;

    localparam logic [7:0] RESET_VAL = 8'h00;

    // frame-end warning lead
    localparam int FRAME_WARN_CLKS   = 10;
    // frame period: 1 ms at 100 MHz
    localparam int FRAME_TIME_US     = 1000;
    localparam int CLK_MHZ           = 100;
    localparam int FRAME_CLKS        = FRAME_TIME_US * CLK_MHZ;
    // bus reset: single-ended zero longer than 3 ms
    localparam int BUS_RESET_TIME_US = 3000;
    localparam int BUS_RESET_CLKS    = BUS_RESET_TIME_US * CLK_MHZ;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // endpoint control/status activity, one bit per endpoint
    typedef struct packed {
        logic [NUM_EP-1:0] rx_out_set;
        logic [NUM_EP-1:0] rx_setup_set;
        logic [NUM_EP-1:0] tx_complete_set;
        logic [NUM_EP-1:0] tx_ready_clr;
        logic [NUM_EP-1:0] stall_sent_set;
    } uhif_ep_evt_t;

    // endpoint types: 1 = control endpoint, else direction from is_in
    typedef struct packed {
        logic [NUM_EP-1:0] is_ctrl;
        logic [NUM_EP-1:0] is_in;
    } uhif_ep_cfg_t;

endpackage : uhif_pkg

// File: uhif_ep_detect.sv
// per-endpoint interrupt trigger decode
// assumes endpoint event inputs are single-cycle pulses on the core clock
`timescale 1ns/10ps
`default_nettype none
module uhif_ep_detect
(
    input  wire uhif_pkg::uhif_ep_evt_t i_evt,
    input  wire uhif_pkg::uhif_ep_cfg_t i_cfg,
    output logic [uhif_pkg::NUM_EP-1:0] o_trig
);
    genvar g;
    generate
        for (g = 0; g < uhif_pkg::NUM_EP; g++)
        begin : g_ep
            logic out_ok;
            logic in_ok;
            assign out_ok = i_cfg.is_ctrl[g] | ~i_cfg.is_in[g];
            assign in_ok  = i_cfg.is_ctrl[g] | i_cfg.is_in[g];
            assign o_trig[g] = (i_evt.rx_out_set[g] & out_ok)
                             | (i_evt.tx_complete_set[g] & in_ok)
                             | (i_evt.stall_sent_set[g] & in_ok)
                             | (i_evt.rx_setup_set[g] & i_cfg.is_ctrl[g]);
        end
    endgenerate
endmodule // uhif_ep_detect
`default_nettype wire

// File: uhif_usb_model.sv
// usb engine stand-in: frame starts, endpoint activity, bus pins
// assumes the bench calls its tasks; everything moves just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module uhif_usb_model
(
    input  wire logic           i_core_clk,
    output logic                o_sof_valid,
    output uhif_pkg::uhif_ep_evt_t o_ep_evt,
    output logic [3:0]          o_pins
);
    // pins: 3 wakeup, 2 resume, 1 global suspend, 0 single-ended zero
    initial
    begin
        o_sof_valid = 1'b0;
        o_ep_evt    = '0;
        o_pins      = 4'h0;
    end
    task automatic sof();
        @(posedge i_core_clk) o_sof_valid <= 1'b1;
        @(posedge i_core_clk) o_sof_valid <= 1'b0;
    endtask
    task automatic ep(input int kind, input int n);
        uhif_pkg::uhif_ep_evt_t e;
        e = '0;
        case (kind)
            0: e.rx_out_set[n] = 1'b1;
            1: e.rx_setup_set[n] = 1'b1;
            2:
            begin
                e.tx_complete_set[n] = 1'b1;
                e.tx_ready_clr[n]    = 1'b1;
            end
            default: e.stall_sent_set[n] = 1'b1;
        endcase
        @(posedge i_core_clk) o_ep_evt <= e;
        @(posedge i_core_clk) o_ep_evt <= '0;
    endtask
    // pins stay high long enough to pass the two-flop synchroniser
    task automatic pin(input int p, input int len);
        @(posedge i_core_clk) o_pins[p] <= 1'b1;
        repeat (len) @(posedge i_core_clk);
        o_pins[p] <= 1'b0;
    endtask
endmodule // uhif_usb_model
`default_nettype wire

// File: test_usb_hub_interrupt_flags.sv
// self-checking bench for the interrupt flag block over ahb-lite
// assumes zero-wait slave, shortened frame and bus-reset counts
`timescale 1ns/10ps
`default_nettype none
module test_usb_hub_interrupt_flags;
    localparam int FRM = 50;
    localparam int BRS = 20;
    logic        clk, rst, hsel, hwrite, sof, irq, hready, hresp, eng_rst, cpu_rst;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0]  pins;
    uhif_pkg::uhif_ep_evt_t evt;
    int          n_fail, checks_done, cyc, n_eng, n_cpu;

    uhif_top #(.FRAME_CLKS(FRM), .BUS_RESET_CLKS(BRS)) u_dut (
        .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_sof_valid(sof), .i_ep_evt(evt), .i_ext_wakeup(pins[3]),
        .i_port_resume(pins[2]), .i_glb_suspend(pins[1]), .i_se0(pins[0]),
        .o_usb_engine_reset(eng_rst), .o_cpu_reset(cpu_rst), .o_irq(irq));
    uhif_usb_model u_usb (.i_core_clk(clk), .o_sof_valid(sof), .o_ep_evt(evt), .o_pins(pins));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // one-cycle reset pulses are counted here so no scenario can miss them
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (eng_rst === 1'b1) n_eng <= n_eng + 1;
        if (cpu_rst === 1'b1) n_cpu <= n_cpu + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    function automatic logic [31:0] ad(input logic [15:0] idx);
        return {16'h0, idx[13:0], 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // irq follows registers written at the edge; look mid-cycle once settled
    task automatic chk_irq(input logic exp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= uhif_pkg::HTRANS_NONSEQ; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        ahb(1'b1, ad(idx), {24'h0, d});
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        ahb(1'b0, ad(idx), 32'h0);
        chk(rd, {24'h0, exp});
    endtask

    task automatic t_reset_values();
        rdc(uhif_pkg::IDX_EVENT_STATUS, 8'h00);
        rdc(uhif_pkg::IDX_EVENT_ENABLE, 8'h00);
        rdc(uhif_pkg::IDX_SR_ENABLE, 8'h00);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h00);
        wr(uhif_pkg::IDX_EVENT_ENABLE, 8'hff);
        rdc(uhif_pkg::IDX_EVENT_ENABLE, uhif_pkg::EVENT_MASK);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'hff);
        rdc(uhif_pkg::IDX_SR_ENABLE, 8'h0f);
        rdc(uhif_pkg::IDX_EVENT_ACK, 8'h00);
        ahb(1'b0, 32'h0000_0100, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wr(uhif_pkg::IDX_EVENT_ENABLE, 8'h00);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'h00);
    endtask
    // endpoint type decides which control/status changes raise the flag
    task automatic t_endpoints();
        logic [15:0] tbl [8];
        tbl = '{16'h0001, 16'h0010, 16'h0020, 16'h0f21, 16'h0f31, 16'h0f00, 16'hf011, 16'hf001};
        // frame timer runs from reset with no start-of-frame: flush its warning first
        repeat (FRM) @(posedge clk);
        rdc(uhif_pkg::IDX_EVENT_STATUS, 8'h40);
        wr(uhif_pkg::IDX_EVENT_ACK, 8'hff);
        for (int n = 0; n < 4; n++)
            for (int i = 0; i < 8; i++)
            begin
                wr(uhif_pkg::IDX_EP_CTRL, tbl[i][15:8]);
                u_usb.ep(int'(tbl[i][7:4]), n);
                rdc(uhif_pkg::IDX_EVENT_STATUS, tbl[i][0] ? 8'(1 << n) : 8'h00);
                wr(uhif_pkg::IDX_EVENT_ACK, 8'hff);
            end
    endtask
    task automatic t_frame_ack_irq();
        u_usb.sof();
        u_usb.ep(0, 0);
        wr(uhif_pkg::IDX_EVENT_ACK, 8'h40);
        rdc(uhif_pkg::IDX_EVENT_STATUS, 8'h81);
        chk_irq(1'b0);
        wr(uhif_pkg::IDX_EVENT_ENABLE, 8'h80);
        chk_irq(1'b1);
        wr(uhif_pkg::IDX_EVENT_ACK, 8'h80);
        rdc(uhif_pkg::IDX_EVENT_STATUS, 8'h01);
        chk_irq(1'b0);
        repeat (FRM) @(posedge clk);
        rdc(uhif_pkg::IDX_EVENT_STATUS, 8'h41);
        wr(uhif_pkg::IDX_EVENT_ENABLE, 8'h40);
        chk_irq(1'b1);
        wr(uhif_pkg::IDX_EVENT_ENABLE, 8'h00);
        wr(uhif_pkg::IDX_EVENT_ACK, 8'hff);
    endtask
    task automatic t_suspend_resume();
        u_usb.pin(3, 4);
        u_usb.pin(2, 4);
        u_usb.pin(1, 4);
        repeat (6) @(posedge clk);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h07);
        chk_irq(1'b0);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'h01);
        chk_irq(1'b1);
        wr(uhif_pkg::IDX_SR_STATUS, 8'h06);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h06);
        chk_irq(1'b0);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'h06);
        chk_irq(1'b1);
        wr(uhif_pkg::IDX_SR_STATUS, 8'h00);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h00);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'h00);
    endtask
    task automatic t_bus_reset();
        u_usb.pin(0, BRS + 5);
        repeat (8) @(posedge clk);
        chk(32'(n_cpu), 32'h1);
        chk(32'(n_eng), 32'h1);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h00);
        wr(uhif_pkg::IDX_SR_ENABLE, 8'h08);
        u_usb.pin(0, BRS + 5);
        repeat (8) @(posedge clk);
        chk(32'(n_cpu), 32'h1);
        chk(32'(n_eng), 32'h2);
        rdc(uhif_pkg::IDX_SR_STATUS, 8'h08);
        chk_irq(1'b1);
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        n_fail = 0; checks_done = 0; cyc = 0; n_eng = 0; n_cpu = 0;
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hwdata = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_endpoints();
        t_frame_ack_irq();
        t_suspend_resume();
        t_bus_reset();
        conclude();
    end
endmodule // test_usb_hub_interrupt_flags
`default_nettype wire
